// ==== flash_prot_pkg.sv ====
// Shared constants and carriers for the program-memory protection checker.
// Assumes a 22-bit program/configuration byte address space and a 32-bit Avalon-MM slave port.
package flash_prot_pkg;

  localparam int unsigned ADDR_W = 22;
  localparam int unsigned AV_AW  = 2;
  localparam int unsigned AV_DW  = 32;

  // Avalon word offsets of the register file
  localparam logic [AV_AW-1:0] OFS_WPH      = 2'h0;
  localparam logic [AV_AW-1:0] OFS_TRP      = 2'h1;
  localparam logic [AV_AW-1:0] OFS_STATUS   = 2'h2;
  localparam logic [AV_AW-1:0] OFS_LASTADDR = 2'h3;

  // Configuration byte addresses of the two protection bytes
  localparam logic [ADDR_W-1:0] CFG_WPH_BYTE_ADDR = 22'h30000B;
  localparam logic [ADDR_W-1:0] CFG_TRP_BYTE_ADDR = 22'h30000C;

  // Write-protect byte fields
  localparam int unsigned WPH_EEPROM_BIT = 7;
  localparam int unsigned WPH_BOOT_BIT   = 6;
  localparam int unsigned WPH_CFG_BIT    = 5;
  localparam logic [7:0]  WPH_IMPL_MASK  = 8'hE0;
  localparam logic [7:0]  WPH_CLR_MASK   = 8'hC0;
  localparam logic [7:0]  WPH_RO_MASK    = 8'h20;
  localparam logic [7:0]  WPH_RESET      = 8'hE0;

  // Table-read protect byte fields, bit i guards block i
  localparam int unsigned TRP_BLOCKS    = 4;
  localparam logic [7:0]  TRP_IMPL_MASK = 8'h0F;
  localparam logic [7:0]  TRP_RESET     = 8'h0F;

  // Status word fields
  localparam int unsigned STS_SEEN_BIT    = 0;
  localparam int unsigned STS_LASTWR_BIT  = 1;
  localparam int unsigned STS_CAUSE_LSB   = 2;
  localparam int unsigned STS_PROG_BIT    = 8;
  localparam int unsigned STS_CNT_LSB     = 16;
  localparam int unsigned STS_CNT_CLR_BIT = 16;
  localparam logic [15:0] DENY_CNT_MAX    = 16'hFFFF;

  // Address map
  localparam logic [ADDR_W-1:0] BOOT_LO = 22'h000000;
  localparam logic [ADDR_W-1:0] BOOT_HI = 22'h0007FF;
  localparam logic [ADDR_W-1:0] BLK0_LO = 22'h000800;
  localparam logic [ADDR_W-1:0] BLK0_HI = 22'h003FFF;
  localparam logic [ADDR_W-1:0] BLK1_LO = 22'h004000;
  localparam logic [ADDR_W-1:0] BLK1_HI = 22'h007FFF;
  localparam logic [ADDR_W-1:0] BLK2_LO = 22'h008000;
  localparam logic [ADDR_W-1:0] BLK2_HI = 22'h00BFFF;
  localparam logic [ADDR_W-1:0] BLK3_LO = 22'h00C000;
  localparam logic [ADDR_W-1:0] BLK3_HI = 22'h00FFFF;
  localparam logic [ADDR_W-1:0] CFG_LO  = 22'h300000;
  localparam logic [ADDR_W-1:0] CFG_HI  = 22'h3000FF;

  typedef enum logic [2:0] {
    CAUSE_NONE  = 3'b000,
    CAUSE_BOOT  = 3'b001,
    CAUSE_CFG   = 3'b010,
    CAUSE_RD_B0 = 3'b100,
    CAUSE_RD_B1 = 3'b101,
    CAUSE_RD_B2 = 3'b110,
    CAUSE_RD_B3 = 3'b111
  } cause_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] addr;
  } chk_req_t;

  typedef struct packed {
    logic   allow;
    cause_t cause;
  } chk_rsp_t;

endpackage : flash_prot_pkg

// ==== prot_region_decode.sv ====
// Address decoder: tells which protected region a program-space byte address falls in.
// Assumes the address is stable for the cycle in which its result is used.
module prot_region_decode
  import flash_prot_pkg::*;
(
  input  wire logic [ADDR_W-1:0]     addr,
  output logic                       in_boot,
  output logic                       in_cfg,
  output logic [TRP_BLOCKS-1:0]      blk_hit
);

  always_comb begin
    in_boot    = (addr >= BOOT_LO) && (addr <= BOOT_HI);
    in_cfg     = (addr >= CFG_LO) && (addr <= CFG_HI);
    blk_hit[0] = (addr >= BLK0_LO) && (addr <= BLK0_HI);
    blk_hit[1] = (addr >= BLK1_LO) && (addr <= BLK1_HI);
    blk_hit[2] = (addr >= BLK2_LO) && (addr <= BLK2_HI);
    blk_hit[3] = (addr >= BLK3_LO) && (addr <= BLK3_HI);
  end

endmodule : prot_region_decode

// ==== flash_block_protection_check.sv ====
// Protection checker for program-memory writes and table reads, with its protection bytes on Avalon-MM.
// Assumes the core presents one access at a time on CHK_VALID/CHK_REQ and that PROG_MODE is synchronous.
//
// What this block does
// - Boot write-lock bit 6 clear denies writes to 000000h-0007FFh; set allows them.
// - Config write-lock bit 5 clear blocks writes to 300000h-3000FFh; set allows.
// - Config write-lock bit is read-only normally, changeable only in programming mode.
// - Bits 4 to 0 of the write-protect byte read as zero.
// - Block-3 guard clear denies table reads of 00C000h-00FFFFh from code outside block 3.
// - Block-2 guard clear denies table reads of 008000h-00BFFFh from code outside block 2.
// - Block-0 guard clear denies table reads of 000800h-003FFFh from code outside block 0.
// - Bits 7 to 4 of the table-read protect byte read as zero.
// - Protection bits are one when unprogrammed; ordinary code can only clear them.
// - Table-read protect byte sits at 30000Ch, guards in bits three down to zero.
// - Write-protect byte sits at 30000Bh, with the EEPROM write-lock in bit seven.
//
// The address map and the Avalon-MM slave port were decided locally.
module flash_block_protection_check
  import flash_prot_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              PROG_MODE,
  input  wire logic [AV_AW-1:0]  AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [AV_DW-1:0]  AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [AV_DW-1:0]  AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  input  wire logic              CHK_VALID,
  input  wire chk_req_t          CHK_REQ,
  output logic                   CHK_DONE,
  output chk_rsp_t               CHK_RSP
);

  // Protection bytes
  logic [7:0]            wph_q;
  logic [7:0]            wph_d;
  logic [7:0]            trp_q;
  logic [7:0]            trp_d;

  // Bus handshake
  logic                  wait_q;
  logic [AV_DW-1:0]      rdata_q;
  logic [AV_DW-1:0]      rdata_d;
  logic                  bus_req;
  logic                  wr_fire;
  logic                  cfg_open;

  // Check path
  logic                  tgt_boot;
  logic                  tgt_cfg;
  logic [TRP_BLOCKS-1:0] tgt_blk;
  logic                  src_boot;
  logic                  src_cfg;
  logic [TRP_BLOCKS-1:0] src_blk;
  logic                  boot_wr_deny;
  logic                  cfg_wr_deny;
  logic [TRP_BLOCKS-1:0] rd_deny;
  logic                  deny;
  cause_t                cause;
  logic                  done_q;
  chk_rsp_t              rsp_q;

  // Deny record
  logic                  seen_q;
  logic                  last_wr_q;
  cause_t                last_cause_q;
  logic [15:0]           cnt_q;
  logic [ADDR_W-1:0]     last_addr_q;
  logic                  deny_evt;
  logic                  sts_wr;

  prot_region_decode u_tgt_decode (
    .addr    (CHK_REQ.addr),
    .in_boot (tgt_boot),
    .in_cfg  (tgt_cfg),
    .blk_hit (tgt_blk)
  );

  // Source decode: only the block membership of the issuing code matters
  prot_region_decode u_src_decode (
    .addr    (CHK_REQ.src),
    .in_boot (src_boot),
    .in_cfg  (src_cfg),
    .blk_hit (src_blk)
  );

  // ---------------- Access check ----------------

  always_comb begin
    boot_wr_deny = CHK_REQ.write && tgt_boot && !wph_q[WPH_BOOT_BIT];
    cfg_wr_deny  = CHK_REQ.write && tgt_cfg && !wph_q[WPH_CFG_BIT];
  end

  // Per-block table-read guard: a read from inside the same block always passes
  genvar gi;
  generate
    for (gi = 0; gi < TRP_BLOCKS; gi++) begin : g_guard
      always_comb begin
        rd_deny[gi] = !CHK_REQ.write && tgt_blk[gi] && !src_blk[gi] && !trp_q[gi];
      end
    end
  endgenerate

  always_comb begin
    deny  = boot_wr_deny || cfg_wr_deny || (rd_deny != '0);
    cause = CAUSE_NONE;
    if (boot_wr_deny) begin
      cause = CAUSE_BOOT;
    end else if (cfg_wr_deny) begin
      cause = CAUSE_CFG;
    end else if (rd_deny[0]) begin
      cause = CAUSE_RD_B0;
    end else if (rd_deny[1]) begin
      cause = CAUSE_RD_B1;
    end else if (rd_deny[2]) begin
      cause = CAUSE_RD_B2;
    end else if (rd_deny[3]) begin
      cause = CAUSE_RD_B3;
    end
  end

  // Answer one cycle after the request: CHK_DONE pulses for one cycle, the response is held until the next request
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= CHK_VALID;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rsp_q <= '{allow: 1'b0, cause: CAUSE_NONE};
    end else if (CHK_VALID) begin
      rsp_q.allow <= !deny;
      rsp_q.cause <= cause;
    end
  end

  // ---------------- Avalon handshake ----------------

  always_comb begin
    bus_req  = AVS_READ || AVS_WRITE;
    wr_fire  = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];
    // Protection bytes live in configuration space, so the config lock guards them too
    cfg_open = PROG_MODE || wph_q[WPH_CFG_BIT];
    sts_wr   = wr_fire && (AVS_ADDRESS == OFS_STATUS);
  end

  // One wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(bus_req && wait_q);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (AVS_READ && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------- Protection bytes ----------------

  always_comb begin
    wph_d = wph_q;
    trp_d = trp_q;
    if (PROG_MODE) begin
      wph_d = AVS_WRITEDATA[7:0] & WPH_IMPL_MASK;
      trp_d = AVS_WRITEDATA[7:0] & TRP_IMPL_MASK;
    end else begin
      // Normal code can only clear; the config lock keeps its value
      wph_d = (wph_q & AVS_WRITEDATA[7:0] & WPH_CLR_MASK) | (wph_q & WPH_RO_MASK);
      trp_d = trp_q & AVS_WRITEDATA[7:0] & TRP_IMPL_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wph_q <= WPH_RESET;
    end else if (wr_fire && cfg_open && (AVS_ADDRESS == OFS_WPH)) begin
      wph_q <= wph_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      trp_q <= TRP_RESET;
    end else if (wr_fire && cfg_open && (AVS_ADDRESS == OFS_TRP)) begin
      trp_q <= trp_d;
    end
  end

  // ---------------- Deny record ----------------

  always_comb begin
    deny_evt = CHK_VALID && deny;
  end

  // Sticky flag: a new denial wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      seen_q <= 1'b0;
    end else if (deny_evt) begin
      seen_q <= 1'b1;
    end else if (sts_wr && AVS_WRITEDATA[STS_SEEN_BIT]) begin
      seen_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_q <= '0;
    end else if (deny_evt && sts_wr && AVS_WRITEDATA[STS_CNT_CLR_BIT]) begin
      cnt_q <= 16'h0001;
    end else if (sts_wr && AVS_WRITEDATA[STS_CNT_CLR_BIT]) begin
      cnt_q <= '0;
    end else if (deny_evt && (cnt_q != DENY_CNT_MAX)) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      last_wr_q    <= 1'b0;
      last_cause_q <= CAUSE_NONE;
      last_addr_q  <= '0;
    end else if (deny_evt) begin
      last_wr_q    <= CHK_REQ.write;
      last_cause_q <= cause;
      last_addr_q  <= CHK_REQ.addr;
    end
  end

  // ---------------- Read back ----------------

  always_comb begin
    rdata_d = '0;
    unique case (AVS_ADDRESS)
      OFS_WPH: begin
        // Image of the byte at CFG_WPH_BYTE_ADDR, low five bits zero
        rdata_d[7:0] = wph_q & WPH_IMPL_MASK;
      end
      OFS_TRP: begin
        // Image of the byte at CFG_TRP_BYTE_ADDR, high nibble zero
        rdata_d[7:0] = trp_q & TRP_IMPL_MASK;
      end
      OFS_STATUS: begin
        rdata_d[STS_SEEN_BIT]          = seen_q;
        rdata_d[STS_LASTWR_BIT]        = last_wr_q;
        rdata_d[STS_CAUSE_LSB +: 3]    = last_cause_q;
        rdata_d[STS_PROG_BIT]          = PROG_MODE;
        rdata_d[STS_CNT_LSB +: 16]     = cnt_q;
      end
      OFS_LASTADDR: begin
        rdata_d[ADDR_W-1:0] = last_addr_q;
      end
    endcase
  end

  // ---------------- Outputs ----------------

  always_comb begin
    AVS_READDATA    = rdata_q;
    AVS_WAITREQUEST = wait_q;
    CHK_DONE        = done_q;
    CHK_RSP         = rsp_q;
  end

endmodule : flash_block_protection_check

// ==== fbpc_props.sv ====
// Assertion checker watching the ports of the protection checker.
// Assumes it is bound to the design top and that CLK and SYS_RST form its one domain.
module fbpc_props
  import flash_prot_pkg::*;
(
  input wire logic             CLK,
  input wire logic             SYS_RST,
  input wire logic             PROG_MODE,
  input wire logic [AV_AW-1:0] AVS_ADDRESS,
  input wire logic             AVS_READ,
  input wire logic             AVS_WRITE,
  input wire logic [AV_DW-1:0] AVS_WRITEDATA,
  input wire logic [3:0]       AVS_BYTEENABLE,
  input wire logic [AV_DW-1:0] AVS_READDATA,
  input wire logic             AVS_WAITREQUEST,
  input wire logic             CHK_VALID,
  input wire chk_req_t         CHK_REQ,
  input wire logic             CHK_DONE,
  input wire chk_rsp_t         CHK_RSP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire logic wr = CHK_VALID && CHK_REQ.write;
  wire logic rd = CHK_VALID && !CHK_REQ.write;
  // Block index 0..3, or 4 outside the guarded blocks
  function automatic logic [2:0] blk_of(input logic [ADDR_W-1:0] a);
    if (a < BLK0_LO || a > BLK3_HI) return 3'h4;
    return {1'b0, a[15:14]};
  endfunction : blk_of
  boot_deny_a: assert property (
    wr && CHK_REQ.addr <= BOOT_HI |=> CHK_RSP.allow || CHK_RSP.cause == CAUSE_BOOT) else $error("boot write cause");
  cfg_deny_a: assert property (
    wr && CHK_REQ.addr inside {[CFG_LO:CFG_HI]} |=> CHK_RSP.allow || CHK_RSP.cause == CAUSE_CFG) else $error("cfg cause");
  wr_free_a: assert property (
    wr && CHK_REQ.addr inside {[BLK0_LO:BLK3_HI]} |=> CHK_RSP.allow) else $error("block write denied");
  rd_free_a: assert property (
    rd && blk_of(CHK_REQ.addr) == 3'h4 |=> CHK_RSP.allow) else $error("unguarded read denied");
  own_blk_a: assert property (
    rd && blk_of(CHK_REQ.addr) != 3'h4 && blk_of(CHK_REQ.src) == blk_of(CHK_REQ.addr) |=> CHK_RSP.allow)
    else $error("own block read denied");
  foreign_blk_a: assert property (
    rd && blk_of(CHK_REQ.addr) != 3'h4 |=> CHK_RSP.allow || CHK_RSP.cause == cause_t'({1'b1, $past(CHK_REQ.addr[15:14])}))
    else $error("read denial cause");
  done_lat_a: assert property (CHK_VALID |=> CHK_DONE ##1 (CHK_DONE == $past(CHK_VALID))) else $error("done latency");
  wait_one_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("wait cycle");
  wph_zero_a: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_WPH |-> AVS_READDATA[4:0] == 5'h00 && AVS_READDATA[31:8] == 24'h0)
    else $error("write-protect byte spare bits");
  trp_zero_a: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_TRP |-> AVS_READDATA[31:4] == 28'h0) else $error("guard byte spare bits");
endmodule : fbpc_props

// ==== core_model.sv ====
// Model of the processor core issuing program writes and table reads.
// Assumes the checker takes one request per rising edge with CHK_VALID high.
module core_model
  import flash_prot_pkg::*;
(
  input  wire logic clk,
  output logic      valid,
  output chk_req_t  req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid = 1'b0;
    req   = '0;
  end
  task automatic issue(input logic w, input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    valid <= 1'b1;
    req   <= '{write: w, src: s, addr: a};
    @(posedge clk);
    valid <= 1'b0;
    // Stale fields are scrambled so the checker cannot lean on them
    req   <= chk_req_t'(~req);
  endtask : issue
endmodule : core_model

// ==== flash_block_protection_check_tb_top.sv ====
// Self-checking bench: Avalon-MM register tasks and core access checks.
// Assumes the package, design, checker and core model are compiled first.
module flash_block_protection_check_tb_top
  import flash_prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, sys_rst, prog_mode, rd_q, wr_q, chk_valid, chk_done, waitreq;
  logic [AV_AW-1:0]  addr;
  logic [AV_DW-1:0]  wdata, rdata;
  logic [3:0]        be;
  chk_req_t          chk_req;
  chk_rsp_t          chk_rsp;
  int                n_mismatch = 0;
  int                n_tests = 0;
  logic [ADDR_W-1:0] lo [4] = '{BLK0_LO, BLK1_LO, BLK2_LO, BLK3_LO};
  logic [ADDR_W-1:0] hi [4] = '{BLK0_HI, BLK1_HI, BLK2_HI, BLK3_HI};
  flash_block_protection_check dut (.CLK(clk), .SYS_RST(sys_rst), .PROG_MODE(prog_mode), .AVS_ADDRESS(addr),
    .AVS_READ(rd_q), .AVS_WRITE(wr_q), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .CHK_VALID(chk_valid), .CHK_REQ(chk_req), .CHK_DONE(chk_done), .CHK_RSP(chk_rsp));
  core_model core (.clk(clk), .valid(chk_valid), .req(chk_req));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // Request held until waitrequest is sampled low at a rising edge; the watchdog ends a hang
  task automatic bus(input logic w, input logic [AV_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd_q  <= !w;
    wr_q  <= w;
    addr  <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask : bus
  task automatic rd(input logic [AV_AW-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp("readdata", e, q);
  endtask : rd
  task automatic wr(input logic [AV_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic w, input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] a, input logic al,
                     input logic [2:0] c);
    core.issue(w, s, a);
    @(negedge clk);
    cmp("done", 32'h1, {31'h0, chk_done});
    cmp("response", {28'h0, al, c}, {28'h0, chk_rsp});
  endtask : chk
  initial begin
    sys_rst = 1'b1;
    prog_mode = 1'b0;
    rd_q = 1'b0;
    wr_q = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hF;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_WPH, 32'hE0);
    rd(OFS_TRP, 32'h0F);
    wr(OFS_WPH, 32'h00);
    rd(OFS_WPH, 32'h20);
    wr(OFS_WPH, 32'hFF);
    rd(OFS_WPH, 32'h20);
    chk(1'b1, BLK1_LO, BOOT_HI, 1'b0, CAUSE_BOOT);
    chk(1'b1, BLK1_LO, BLK0_LO, 1'b1, CAUSE_NONE);
    chk(1'b1, BLK1_LO, CFG_HI, 1'b1, CAUSE_NONE);
    $display("test write locks done");
    wr(OFS_TRP, 32'h00);
    rd(OFS_TRP, 32'h00);
    for (int i = 0; i < 4; i++) begin
      chk(1'b0, lo[(i + 1) % 4], hi[i], 1'b0, 3'(4 + i));
      chk(1'b0, hi[i], lo[i], 1'b1, CAUSE_NONE);
    end
    chk(1'b0, BOOT_LO, BLK0_LO, 1'b0, CAUSE_RD_B0);
    chk(1'b0, BLK3_LO, BOOT_HI, 1'b1, CAUSE_NONE);
    $display("test read guards done");
    prog_mode <= 1'b1;
    wr(OFS_WPH, 32'hC0);
    rd(OFS_WPH, 32'hC0);
    be <= 4'h0;
    wr(OFS_TRP, 32'h0F);
    rd(OFS_TRP, 32'h00);
    be <= 4'hF;
    wr(OFS_TRP, 32'h0F);
    prog_mode <= 1'b0;
    rd(OFS_TRP, 32'h0F);
    wr(OFS_WPH, 32'h00);
    rd(OFS_WPH, 32'hC0);
    chk(1'b1, BLK1_LO, CFG_LO, 1'b0, CAUSE_CFG);
    chk(1'b1, BLK1_LO, BOOT_LO, 1'b1, CAUSE_NONE);
    chk(1'b0, BLK1_LO, BLK3_LO, 1'b1, CAUSE_NONE);
    $display("test programming mode done");
    rd(OFS_STATUS, 32'h0007000B);
    rd(OFS_LASTADDR, 32'h00300000);
    wr(OFS_STATUS, 32'h00010001);
    rd(OFS_STATUS, 32'h0000000A);
    $display("test deny record done");
    conclude();
  end
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : flash_block_protection_check_tb_top
bind flash_block_protection_check fbpc_props chk_props (.CLK(CLK), .SYS_RST(SYS_RST), .PROG_MODE(PROG_MODE),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CHK_VALID(CHK_VALID), .CHK_REQ(CHK_REQ), .CHK_DONE(CHK_DONE), .CHK_RSP(CHK_RSP));
